// file: pkg/mvu_pkg.sv
package mvu_pkg;

    // Microinstruction word: opcode byte, source field, destination field
    typedef struct packed {
        logic [7:0] opcode;
        logic [3:0] src;
        logic [3:0] dst;
    } mvu_mi_t;

    // Flag register layout, bit 7 down to bit 0
    typedef struct packed {
        logic nb;
        logic zb;
        logic c4;
        logic c8;
        logic n;
        logic z;
        logic v;
        logic c;
    } mvu_flags_t;

    // Classic Wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } mvu_wb_req_t;

    typedef enum logic {
        MVU_IDLE,
        MVU_WORD_HIGH
    } mvu_state_t;

    // Opcode patterns
    localparam logic [3:0] MVU_OP_LITERAL = 4'h6;
    localparam logic [7:0] MVU_OP_POINTER = 8'h75;
    localparam logic [7:0] MVU_OP_TRANSLATION = 8'hEE;
    localparam logic [7:0] MVU_OP_FLAG_COPY = 8'h72;
    localparam logic [7:0] MVU_OP_FLAG_LOAD = 8'h73;
    localparam logic [4:0] MVU_OP_MOVE_CLASS = 5'h10;
    // Positions inside the opcode byte
    localparam int MVU_COND_BIT = 2;
    localparam int MVU_WORD_BIT = 1;
    localparam int MVU_CODES_BIT = 0;

    // Register offsets (byte addresses)
    localparam logic [7:0] MVU_ADR_ISSUE = 8'h00;
    localparam logic [7:0] MVU_ADR_FLAGS = 8'h04;
    localparam logic [7:0] MVU_ADR_POINTER = 8'h08;
    localparam logic [7:0] MVU_ADR_TRANSLATION = 8'h0C;
    localparam logic [7:0] MVU_ADR_STATUS = 8'h10;
    localparam logic [1:0] MVU_ADR_FILE_TOP = 2'h1;

    // Status register bit positions
    localparam int MVU_ST_BUSY = 0;
    localparam int MVU_ST_UNSUPPORTED = 1;
    localparam int MVU_ST_SKIPPED = 2;

    // Values after reset
    localparam logic [7:0] MVU_FLAGS_RESET = 8'h00;
    localparam logic [2:0] MVU_POINTER_RESET = 3'h0;
    localparam logic [15:0] MVU_TRANSLATION_RESET = 16'h0000;
    localparam logic [15:0] MVU_MI_RESET = 16'h0000;
    localparam logic [7:0] MVU_FILE_RESET = 8'h00;

endpackage

// file: hdl/mvu_regfile.sv
`timescale 1ns/1ps
module mvu_regfile
    import mvu_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Read ports
    input wire logic [3:0] rd_a_addr_in,
    input wire logic [3:0] rd_b_addr_in,
    input wire logic [3:0] rd_c_addr_in,
    output logic [7:0] rd_a_data_out,
    output logic [7:0] rd_b_data_out,
    output logic [7:0] rd_c_data_out,
    // Write port
    input wire logic wr_en_in,
    input wire logic [3:0] wr_addr_in,
    input wire logic [7:0] wr_data_in
);

    logic [7:0] file_reg [16];

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            for (int i = 0; i < 16; i++) begin
                file_reg[i] <= MVU_FILE_RESET;
            end
        end else if (wr_en_in) begin
            file_reg[wr_addr_in] <= wr_data_in;
        end
    end

    assign rd_a_data_out = file_reg[rd_a_addr_in];
    assign rd_b_data_out = file_reg[rd_b_addr_in];
    assign rd_c_data_out = file_reg[rd_c_addr_in];

endmodule

// file: hdl/mvu_move_unit.sv
`timescale 1ns/1ps
module mvu_move_unit
    import mvu_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Microsequencer issue port
    input wire logic mi_valid_in,
    input wire mvu_mi_t mi_word_in,
    output logic mi_ready_out,
    // Input-word pointer load
    input wire logic iw_pointer_load_in,
    input wire logic [2:0] iw_pointer_in,
    // Machine state
    output mvu_flags_t flags_out,
    output logic [2:0] pointer_out,
    output logic [15:0] translation_out,
    // Wishbone slave
    input wire mvu_wb_req_t wb_req_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out
);

    ////////////////////////////////////////////////////////////////////////////////
    mvu_state_t state_reg;
    mvu_flags_t flags_reg;
    mvu_flags_t flags_next;
    mvu_mi_t held_mi_reg;
    mvu_mi_t cur_mi;
    logic [2:0] pointer_reg;
    logic [15:0] translation_reg;
    logic low_zero_reg;
    logic unsupported_reg;
    logic skipped_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;

    logic seq_go;
    logic bus_take;
    logic bus_issue;
    logic go;
    logic [3:0] a_addr;
    logic [3:0] b_addr;
    logic [7:0] a_data;
    logic [7:0] b_data;
    logic [7:0] c_data;
    logic wr_en;
    logic [3:0] wr_addr;
    logic [7:0] wr_data;
    logic exec_wr;
    logic [7:0] exec_data;
    logic pointer_load;
    logic tr_load;
    logic flags_load;
    logic start_word;
    logic unsupported_hit;
    logic skip_hit;
    logic take;
    logic is_move;
    logic [7:0] high_byte;
    logic bus_wr_file;
    logic bus_wr_flags;
    logic bus_wr_status;
    logic in_file;

    ////////////////////////////////////////////////////////////////////////////////
    // Issue arbitration: sequencer first, bus issue only when it is quiet
    assign seq_go = mi_valid_in && (state_reg == MVU_IDLE);
    assign bus_take = wb_req_in.cyc && wb_req_in.stb && !ack_reg && !seq_go && (state_reg == MVU_IDLE);
    assign bus_issue = bus_take && wb_req_in.we && (wb_req_in.adr == MVU_ADR_ISSUE) && (&wb_req_in.sel[1:0]);
    assign go = seq_go || bus_issue;
    assign cur_mi = seq_go ? mi_word_in : mvu_mi_t'(wb_req_in.dat[15:0]);
    assign mi_ready_out = (state_reg == MVU_IDLE);
    assign in_file = (wb_req_in.adr[7:6] == MVU_ADR_FILE_TOP);
    assign bus_wr_file = bus_take && wb_req_in.we && in_file && wb_req_in.sel[0];
    assign bus_wr_flags = bus_take && wb_req_in.we && (wb_req_in.adr == MVU_ADR_FLAGS) && wb_req_in.sel[0];
    assign bus_wr_status = bus_take && wb_req_in.we && (wb_req_in.adr == MVU_ADR_STATUS) && wb_req_in.sel[0];
    assign is_move = (cur_mi.opcode[7:3] == MVU_OP_MOVE_CLASS);

    ////////////////////////////////////////////////////////////////////////////////
    // Operand addressing; high cycle flips the dst low bit and sets the src low bit
    always_comb begin
        if (state_reg == MVU_WORD_HIGH) begin
            a_addr = {held_mi_reg.dst[3:1], ~held_mi_reg.dst[0]};
            // Odd source: the low byte is reread for sign extension
            b_addr = held_mi_reg.src[0] ? held_mi_reg.src : {held_mi_reg.src[3:1], 1'b1};
        end else begin
            a_addr = cur_mi.dst;
            b_addr = cur_mi.src;
        end
    end

    assign high_byte = held_mi_reg.src[0] ? {8{b_data[7]}} : b_data;

    mvu_regfile u_file (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .rd_a_addr_in(a_addr),
        .rd_b_addr_in(b_addr),
        .rd_c_addr_in(wb_req_in.adr[5:2]),
        .rd_a_data_out(a_data),
        .rd_b_data_out(b_data),
        .rd_c_data_out(c_data),
        .wr_en_in(wr_en),
        .wr_addr_in(wr_addr),
        .wr_data_in(wr_data)
    );

    // Execution and bus never write in the same cycle: bus is stalled
    assign wr_en = exec_wr || bus_wr_file;
    assign wr_addr = exec_wr ? a_addr : wb_req_in.adr[5:2];
    assign wr_data = exec_wr ? exec_data : wb_req_in.dat[7:0];

    ////////////////////////////////////////////////////////////////////////////////
    // Decode and execute; everything here happens inside the unit
    always_comb begin
        flags_next = flags_reg;
        exec_wr = 1'b0;
        exec_data = 8'h00;
        pointer_load = 1'b0;
        tr_load = 1'b0;
        flags_load = 1'b0;
        start_word = 1'b0;
        unsupported_hit = 1'b0;
        skip_hit = 1'b0;
        take = 1'b0;
        if (state_reg == MVU_WORD_HIGH) begin
            exec_wr = 1'b1;
            exec_data = high_byte;
            flags_load = 1'b1;
            flags_next.nb = high_byte[7];
            flags_next.zb = low_zero_reg && (high_byte == 8'h00);
            if (held_mi_reg.opcode[MVU_CODES_BIT]) begin
                flags_next.n = high_byte[7];
                flags_next.z = low_zero_reg && (high_byte == 8'h00);
                flags_next.v = 1'b0;
            end
        end else if (go) begin
            if (cur_mi.opcode[7:4] == MVU_OP_LITERAL) begin
                exec_wr = 1'b1;
                exec_data = {cur_mi.opcode[3:0], cur_mi.src};
                flags_load = 1'b1;
                flags_next.nb = cur_mi.opcode[3];
                flags_next.zb = ({cur_mi.opcode[3:0], cur_mi.src} == 8'h00);
            end else if (cur_mi.opcode == MVU_OP_POINTER) begin
                pointer_load = 1'b1;
            end else if (cur_mi.opcode == MVU_OP_TRANSLATION) begin
                tr_load = 1'b1;
            end else if (cur_mi.opcode == MVU_OP_FLAG_COPY) begin
                exec_wr = 1'b1;
                exec_data = flags_reg;
            end else if (cur_mi.opcode == MVU_OP_FLAG_LOAD) begin
                flags_load = 1'b1;
                flags_next[7:4] = a_data[7:4];
                for (int i = 0; i < 4; i++) begin
                    if (cur_mi.src[i]) begin
                        flags_next[i] = a_data[i];
                    end
                end
            end else if (is_move) begin
                // Carry sampled before this cycle's update
                take = !cur_mi.opcode[MVU_COND_BIT] || flags_reg.c;
                skip_hit = !take;
                if (take) begin
                    exec_wr = 1'b1;
                    exec_data = b_data;
                    start_word = cur_mi.opcode[MVU_WORD_BIT];
                    if (!cur_mi.opcode[MVU_WORD_BIT]) begin
                        flags_load = 1'b1;
                        flags_next.nb = b_data[7];
                        flags_next.zb = (b_data == 8'h00);
                        if (cur_mi.opcode[MVU_CODES_BIT]) begin
                            flags_next.n = b_data[7];
                            flags_next.z = (b_data == 8'h00);
                            flags_next.v = 1'b0;
                        end
                    end
                end
            end else begin
                unsupported_hit = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencing: word moves return to idle after one high byte cycle
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_reg <= MVU_IDLE;
        end else begin
            case (state_reg)
                MVU_IDLE: begin
                    if (start_word) begin
                        state_reg <= MVU_WORD_HIGH;
                    end
                end
                MVU_WORD_HIGH: begin
                    state_reg <= MVU_IDLE;
                end
                default: begin
                    state_reg <= MVU_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            held_mi_reg <= mvu_mi_t'(MVU_MI_RESET);
            low_zero_reg <= 1'b0;
        end else if (go) begin
            held_mi_reg <= cur_mi;
            low_zero_reg <= (b_data == 8'h00);
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            flags_reg <= mvu_flags_t'(MVU_FLAGS_RESET);
        end else if (flags_load) begin
            flags_reg <= flags_next;
        end else if (bus_wr_flags) begin
            flags_reg <= mvu_flags_t'(wb_req_in.dat[7:0]);
        end
    end

    // Pointer has exactly two writers
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pointer_reg <= MVU_POINTER_RESET;
        end else if (pointer_load) begin
            pointer_reg <= a_data[2:0];
        end else if (iw_pointer_load_in) begin
            pointer_reg <= iw_pointer_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            translation_reg <= MVU_TRANSLATION_RESET;
        end else if (tr_load) begin
            translation_reg <= {b_data, a_data};
        end
    end

    // Sticky status; a new event beats a same-cycle clear
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            unsupported_reg <= 1'b0;
            skipped_reg <= 1'b0;
        end else begin
            if (unsupported_hit) begin
                unsupported_reg <= 1'b1;
            end else if (bus_wr_status && wb_req_in.dat[MVU_ST_UNSUPPORTED]) begin
                unsupported_reg <= 1'b0;
            end
            if (skip_hit) begin
                skipped_reg <= 1'b1;
            end else if (bus_wr_status && wb_req_in.dat[MVU_ST_SKIPPED]) begin
                skipped_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Wishbone: one-cycle answer once taken; unmapped reads zero
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_take;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rdata_reg <= 32'h0000_0000;
        end else if (bus_take) begin
            rdata_reg <= 32'h0000_0000;
            if (in_file) begin
                rdata_reg[7:0] <= c_data;
            end else begin
                case (wb_req_in.adr)
                    MVU_ADR_ISSUE: rdata_reg[15:0] <= held_mi_reg;
                    MVU_ADR_FLAGS: rdata_reg[7:0] <= flags_reg;
                    MVU_ADR_POINTER: rdata_reg[2:0] <= pointer_reg;
                    MVU_ADR_TRANSLATION: rdata_reg[15:0] <= translation_reg;
                    MVU_ADR_STATUS: begin
                        rdata_reg[MVU_ST_BUSY] <= (state_reg != MVU_IDLE);
                        rdata_reg[MVU_ST_UNSUPPORTED] <= unsupported_reg;
                        rdata_reg[MVU_ST_SKIPPED] <= skipped_reg;
                    end
                    default: rdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign wb_ack_out = ack_reg;
    assign wb_dat_out = rdata_reg;
    assign flags_out = flags_reg;
    assign pointer_out = pointer_reg;
    assign translation_out = translation_reg;

endmodule

// file: tb/mvu_seq_model.sv
`timescale 1ns/1ps
module mvu_seq_model
    import mvu_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Issue port towards the move unit
    input wire logic ready_in,
    output logic valid_out,
    output mvu_mi_t word_out
);
    mvu_mi_t pending[$];
    initial begin
        valid_out = 1'b0;
        word_out = MVU_MI_RESET;
    end
    task automatic push(input mvu_mi_t w);
        pending.push_back(w);
    endtask
    function automatic int depth();
        return pending.size();
    endfunction
    // Word stays put while the unit is busy, never dropped
    always @(posedge clk_in) begin
        if (reset_in) begin
            pending.delete();
            valid_out <= 1'b0;
        end else begin
            if (valid_out && ready_in) begin
                void'(pending.pop_front());
            end
            valid_out <= (pending.size() != 0);
            if (pending.size() != 0) begin
                word_out <= pending[0];
            end
        end
    end
endmodule

// file: tb/mvu_move_unit_properties.sv
`timescale 1ns/1ps
module mvu_move_unit_checker
    import mvu_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Issue port
    input wire logic mi_valid_in,
    input wire mvu_mi_t mi_word_in,
    input wire logic mi_ready_out,
    input wire logic iw_pointer_load_in,
    // Machine state
    input wire mvu_flags_t flags_out,
    input wire logic [2:0] pointer_out,
    input wire logic [15:0] translation_out
);
    wire logic take = mi_valid_in && mi_ready_out;
    wire logic [7:0] op = mi_word_in.opcode;
    wire logic [7:0] lit = {op[3:0], mi_word_in.src};
    wire logic mv = take && (op[7:3] == MVU_OP_MOVE_CLASS);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    ////////////////////////////////////////////////////////////////////////
    a_literal_flags: assert property (take && op[7:4] == MVU_OP_LITERAL |=>
        flags_out.nb == $past(lit[7]) && flags_out.zb == ($past(lit) == 8'h00)
        && flags_out[5:0] == $past(flags_out[5:0])) else $error("literal load flags wrong");
    // Reset also clears the pointer, so skip the edge after it
    a_pointer_cause: assert property (!$past(reset_in) && $changed(pointer_out) |->
        $past(take && op == MVU_OP_POINTER) || $past(iw_pointer_load_in)) else $error("pointer changed");
    a_pointer_quiet: assert property (take && op == MVU_OP_POINTER |=>
        $stable(flags_out) && $stable(translation_out)) else $error("pointer load side effect");
    a_trans_cause: assert property (!$past(reset_in) && $changed(translation_out) |->
        $past(take && op == MVU_OP_TRANSLATION)) else $error("translation changed");
    a_trans_quiet: assert property (take && op == MVU_OP_TRANSLATION |=>
        $stable(flags_out)) else $error("translation load touched flags");
    a_copy_quiet: assert property (take && op == MVU_OP_FLAG_COPY |=>
        $stable(flags_out)) else $error("flag copy touched flags");
    a_load_enables: assert property (take && op == MVU_OP_FLAG_LOAD |=>
        (flags_out[3:0] & ~$past(mi_word_in.src)) == ($past(flags_out[3:0]) & ~$past(mi_word_in.src)))
        else $error("disabled code written");
    a_code_move: assert property (mv && !op[MVU_WORD_BIT] && !op[MVU_COND_BIT] && op[MVU_CODES_BIT] |=>
        !flags_out.v && flags_out.n == flags_out.nb && flags_out.z == flags_out.zb
        && flags_out.c == $past(flags_out.c) && flags_out[5:4] == $past(flags_out[5:4]))
        else $error("code move flags wrong");
    a_plain_move: assert property (mv && !op[MVU_WORD_BIT] && !op[MVU_CODES_BIT] |=>
        flags_out[3:0] == $past(flags_out[3:0])) else $error("plain move changed codes");
    a_skip_move: assert property (mv && op[MVU_COND_BIT] && !flags_out.c |=>
        $stable(flags_out)) else $error("skipped move changed flags");
    // A carry-gated word move that goes ahead also needs the high byte cycle
    a_one_cycle: assert property (take && !(mv && op[MVU_WORD_BIT]
        && (!op[MVU_COND_BIT] || flags_out.c)) |=> mi_ready_out) else $error("single cycle op stalled");
    a_word_two: assert property (mv && op[MVU_WORD_BIT] && (!op[MVU_COND_BIT] || flags_out.c) |=>
        !mi_ready_out ##1 mi_ready_out) else $error("word move not two cycles");
endmodule
bind mvu_move_unit mvu_move_unit_checker u_chk (.clk_in(clk_in), .reset_in(reset_in),
    .mi_valid_in(mi_valid_in), .mi_word_in(mi_word_in), .mi_ready_out(mi_ready_out),
    .iw_pointer_load_in(iw_pointer_load_in), .flags_out(flags_out), .pointer_out(pointer_out),
    .translation_out(translation_out));

// file: tb/tb_move_microinstruction_unit.sv
`timescale 1ns/1ps
module tb_move_microinstruction_unit
    import mvu_pkg::*;
;
    logic clk_in;
    logic reset_in;
    logic iw_load;
    logic [2:0] iw_ptr;
    mvu_wb_req_t wb_req;
    logic [31:0] wb_dat;
    logic wb_ack;
    logic mi_valid;
    logic mi_ready;
    mvu_mi_t mi_word;
    mvu_flags_t flags_o;
    logic [2:0] ptr_o;
    logic [15:0] tr_o;
    int mismatches;
    int num_checks;
    int cycles;
    mvu_move_unit dut (.clk_in(clk_in), .reset_in(reset_in), .mi_valid_in(mi_valid), .mi_word_in(mi_word),
        .mi_ready_out(mi_ready), .iw_pointer_load_in(iw_load), .iw_pointer_in(iw_ptr), .flags_out(flags_o),
        .pointer_out(ptr_o), .translation_out(tr_o), .wb_req_in(wb_req), .wb_dat_out(wb_dat), .wb_ack_out(wb_ack));
    mvu_seq_model seq (.clk_in(clk_in), .reset_in(reset_in), .ready_in(mi_ready), .valid_out(mi_valid),
        .word_out(mi_word));
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Ceiling well above the few hundred cycles the tests need
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
        @(posedge clk_in);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: dat};
        // Wait for the ack; only the bench ceiling ends it if none comes
        do begin
            @(posedge clk_in);
        end while (wb_ack !== 1'b1);
        rd = wb_dat;
        wb_req <= '0;
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] unused;
        wb_cycle(1'b1, adr, dat, unused);
    endtask
    task automatic expect_rd(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] rd;
        wb_cycle(1'b0, adr, 32'h0000_0000, rd);
        check(rd, exp);
    endtask
    function automatic logic [7:0] rf(input int i);
        return 8'h40 + 8'(i * 4);
    endfunction
    task automatic issue(input logic [15:0] w);
        #1;
        seq.push(w);
    endtask
    task automatic drain();
        do begin
            @(posedge clk_in);
            #1;
        end while (seq.depth() != 0 || mi_valid !== 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        expect_rd(MVU_ADR_FLAGS, 32'h0000_0000);
        expect_rd(MVU_ADR_POINTER, 32'h0000_0000);
        expect_rd(MVU_ADR_TRANSLATION, 32'h0000_0000);
        expect_rd(rf(3), 32'h0000_0000);
        expect_rd(8'h20, 32'h0000_0000);
        $display("reset test done");
    endtask
    task automatic test_literal();
        wr(MVU_ADR_FLAGS, 32'h0000_003f);
        issue(16'h6805);
        issue(16'h6006);
        drain();
        expect_rd(rf(5), 32'h0000_0080);
        expect_rd(rf(6), 32'h0000_0000);
        expect_rd(MVU_ADR_FLAGS, 32'h0000_007f);
        $display("literal test done");
    endtask
    task automatic test_pointer_translation();
        wr(rf(2), 32'h0000_00ad);
        wr(rf(3), 32'h0000_0012);
        issue(16'h7502);
        issue(16'hee32);
        drain();
        check(32'(ptr_o), 32'h0000_0005);
        check(32'(tr_o), 32'h0000_12ad);
        expect_rd(MVU_ADR_POINTER, 32'h0000_0005);
        expect_rd(MVU_ADR_TRANSLATION, 32'h0000_12ad);
        expect_rd(rf(2), 32'h0000_00ad);
        expect_rd(MVU_ADR_FLAGS, 32'h0000_007f);
        @(posedge clk_in);
        iw_load <= 1'b1;
        iw_ptr <= 3'h3;
        @(posedge clk_in);
        iw_load <= 1'b0;
        issue(16'h7203);
        drain();
        expect_rd(MVU_ADR_POINTER, 32'h0000_0003);
        $display("pointer and translation test done");
    endtask
    task automatic test_flags();
        wr(MVU_ADR_FLAGS, 32'h0000_00a5);
        wr(rf(8), 32'h0000_005a);
        issue(16'h7207);
        issue(16'h73a8);
        drain();
        check(32'(flags_o), 32'h0000_005f);
        expect_rd(rf(7), 32'h0000_00a5);
        expect_rd(MVU_ADR_FLAGS, 32'h0000_005f);
        $display("flag copy and load test done");
    endtask
    task automatic test_byte_move();
        wr(MVU_ADR_FLAGS, 32'h0000_003f);
        wr(rf(9), 32'h0000_0080);
        issue(16'h8092);
        drain();
        expect_rd(MVU_ADR_FLAGS, 32'h0000_00bf);
        issue(16'h8193);
        drain();
        expect_rd(rf(2), 32'h0000_0080);
        expect_rd(rf(3), 32'h0000_0080);
        expect_rd(rf(9), 32'h0000_0080);
        expect_rd(MVU_ADR_FLAGS, 32'h0000_00b9);
        $display("byte move test done");
    endtask
    task automatic test_gated_move();
        wr(MVU_ADR_FLAGS, 32'h0000_0000);
        wr(rf(4), 32'h0000_0077);
        issue(16'h85a4);
        drain();
        expect_rd(rf(4), 32'h0000_0077);
        expect_rd(MVU_ADR_FLAGS, 32'h0000_0000);
        wr(MVU_ADR_FLAGS, 32'h0000_0001);
        issue(16'h85a4);
        drain();
        expect_rd(rf(4), 32'h0000_0000);
        expect_rd(MVU_ADR_FLAGS, 32'h0000_0045);
        expect_rd(MVU_ADR_STATUS, 32'h0000_0004);
        wr(MVU_ADR_STATUS, 32'h0000_0004);
        expect_rd(MVU_ADR_STATUS, 32'h0000_0000);
        // Opcode matching no pattern only raises the unsupported bit
        issue(16'h0000);
        drain();
        expect_rd(MVU_ADR_STATUS, 32'h0000_0002);
        $display("carry gated move test done");
    endtask
    // Literal queued behind a word move must wait out the high byte cycle
    task automatic test_word_move();
        wr(rf(12), 32'h0000_0034);
        wr(rf(13), 32'h0000_0092);
        issue(16'h82ce);
        issue(16'h6550);
        drain();
        expect_rd(rf(14), 32'h0000_0034);
        expect_rd(rf(15), 32'h0000_0092);
        expect_rd(rf(0), 32'h0000_0055);
        expect_rd(MVU_ADR_FLAGS, 32'h0000_0005);
        // Same literal path reached through the issue register
        wr(MVU_ADR_ISSUE, 32'h0000_6a01);
        expect_rd(rf(1), 32'h0000_00a0);
        expect_rd(MVU_ADR_ISSUE, 32'h0000_6a01);
        expect_rd(MVU_ADR_FLAGS, 32'h0000_0085);
        $display("word move test done");
    endtask
    initial begin
        mismatches = 0;
        num_checks = 0;
        cycles = 0;
        reset_in = 1'b1;
        iw_load = 1'b0;
        iw_ptr = 3'h0;
        wb_req = '0;
        repeat (12) @(posedge clk_in);
        reset_in <= 1'b0;
        test_reset();
        test_literal();
        test_pointer_translation();
        test_flags();
        test_byte_move();
        test_gated_move();
        test_word_move();
        complete_run();
    end
endmodule
